// ---- i2cs_pkg.sv ----
// Package for the slave-transmit serial port with bus monitor.
// Assumes an AXI4-Lite master on aclk and open-drain pins resolved outside.
package i2cs_pkg;
  // ***********************************************************
  // Register map (byte addresses)
  // ***********************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BUF = 8'h08;
  localparam logic [7:0] ADDR_OWN = 8'h0c;
  localparam logic [7:0] ADDR_PORT = 8'h10;
  localparam logic [7:0] ADDR_IRQ = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;
  // Control field positions
  localparam int CTL_MODE_LO = 0;
  localparam int CTL_REL = 4;
  localparam int CTL_EN = 5;
  localparam int CTL_OVF = 6;
  // Status field positions
  localparam int ST_FULL = 0;
  localparam int ST_RW = 2;
  localparam int ST_START = 3;
  localparam int ST_STOP = 4;
  localparam int ST_DATA = 5;
  localparam int ST_FREE = 6;
  // Interrupt bits
  localparam int IRQ_BYTE = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_STOP = 2;
  // Port direction bits
  localparam int DIR_SCL = 3;
  localparam int DIR_SDA = 4;
  // Reset values, mode codes and response codes
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [2:0] RST_MASK = 3'h0;
  localparam logic [3:0] MODE_SLAVE7 = 4'h6;
  localparam logic [3:0] MODE_IDLE_MON = 4'hb;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2cs_pins_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_TX = 5'b00100,
    ST_ACKIN = 5'b01000,
    ST_RX = 5'b10000
  } i2cs_state_t;
endpackage

// ---- i2cs_top.sv ----
// Slave-transmit serial port with start/stop bus monitor and AXI4-Lite regs.
// Assumes SCL/SDA are external open-drain wires, sampled here on aclk.
`timescale 1ns/1ps
// Behaviour
// - Matching read address sets direction, loads buffer
// - Acknowledge address, then clear release bit
// - Buffer write also loads shift register
// - Hold SCL low until release bit set
// - First bit out while SCL held, other seven on SCL falls
// - Flag on ninth falling edge, software clears
// - Sample master acknowledge on ninth rise
// - No acknowledge resets slave, awaits start
// - Acknowledge: hold SCL for next byte
// - Start/stop flags cleared by reset, disable
// - Bus free: stop seen, or neither
// - Master pins open drain, always drive low
// - Direction bit high releases, low drives zero
// - Interrupt on start, stop, byte done
// - Mode 1011 idle slave with start/stop interrupts
// - Separate start, stop, byte status bits
module i2cs_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire i2cs_pkg::i2cs_pins_t pin_in,
  output i2cs_pkg::i2cs_pins_t pin_out,
  output i2cs_pkg::i2cs_pins_t pin_oe,
  output logic irq
);
  import i2cs_pkg::*;

  // ***********************************************************
  // Pin synchronisers and edge detection
  // ***********************************************************
  i2cs_pins_t sync1, sync2, prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '{scl: 1'b1, sda: 1'b1};
      sync2 <= '{scl: 1'b1, sda: 1'b1};
      prev <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      prev <= sync2;
    end
  end
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = sync2.scl & ~prev.scl;
  assign scl_fall = ~sync2.scl & prev.scl;
  assign start_det = sync2.scl & prev.scl & prev.sda & ~sync2.sda;
  assign stop_det = sync2.scl & prev.scl & ~prev.sda & sync2.sda;

  // ***********************************************************
  // State
  // ***********************************************************
  logic [7:0] ctrl, next_ctrl, own, next_own, buf_q, next_buf;
  logic [7:0] sr, next_sr, dir, next_dir;
  logic full, next_full, rw, next_rw, s_f, next_s_f, p_f, next_p_f;
  logic da, next_da, sda_lo, next_sda_lo, scl_lo, next_scl_lo;
  logic [3:0] cnt, next_cnt;
  logic [2:0] ist, next_ist, mask, next_mask;
  i2cs_state_t st, next_st;
  logic aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [7:0] aw_a, next_aw_a;
  logic [31:0] w_d, next_w_d;
  logic [3:0] w_s, next_w_s;
  logic bvalid, next_bvalid, rvalid, next_rvalid, irq_q, next_irq;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;

  function automatic logic known(input logic [7:0] a);
    known = a == ADDR_CTRL || a == ADDR_STATUS || a == ADDR_BUF ||
      a == ADDR_OWN || a == ADDR_PORT || a == ADDR_IRQ || a == ADDR_MASK;
  endfunction

  logic en, slave_on, bus_free;
  assign en = ctrl[CTL_EN];
  assign slave_on = en && ctrl[CTL_MODE_LO +: 4] == MODE_SLAVE7;
  assign bus_free = p_f | (~s_f & ~p_f);

  // ***********************************************************
  // Next-state logic: bus, link and interrupts
  // ***********************************************************
  always_comb begin
    logic wr, rd, do_w;
    logic [7:0] wa;
    logic [2:0] ev;
    next_ctrl = ctrl; next_own = own; next_buf = buf_q; next_sr = sr;
    next_dir = dir; next_full = full; next_rw = rw; next_s_f = s_f;
    next_p_f = p_f; next_da = da; next_sda_lo = sda_lo;
    next_scl_lo = scl_lo; next_cnt = cnt; next_ist = ist;
    next_mask = mask; next_st = st; next_aw_hold = aw_hold;
    next_w_hold = w_hold; next_aw_a = aw_a; next_w_d = w_d;
    next_w_s = w_s; next_bvalid = bvalid; next_rvalid = rvalid;
    next_bresp = bresp; next_rresp = rresp; next_rdata = rdata;
    ev = 3'h0;
    if (s_axi_awvalid && !aw_hold) begin
      next_aw_hold = 1'b1; next_aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold) begin
      next_w_hold = 1'b1; next_w_d = s_axi_wdata; next_w_s = s_axi_wstrb;
    end
    do_w = aw_hold && w_hold && !bvalid;
    wa = aw_a;
    wr = do_w && w_s[0];
    rd = s_axi_arvalid && !rvalid;
    if (s_axi_bready && bvalid) next_bvalid = 1'b0;
    if (s_axi_rready && rvalid) next_rvalid = 1'b0;
    if (rd) begin
      next_rvalid = 1'b1;
      next_rresp = known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_rdata = 32'h0;
      unique case (s_axi_araddr)
        ADDR_CTRL: next_rdata[7:0] = ctrl;
        ADDR_STATUS: next_rdata[7:0] = {1'b0, bus_free, da, p_f, s_f,
          rw, 1'b0, full};
        ADDR_BUF: next_rdata[7:0] = buf_q;
        ADDR_OWN: next_rdata[7:0] = own;
        ADDR_PORT: next_rdata[7:0] = dir;
        ADDR_IRQ: next_rdata[2:0] = ist;
        ADDR_MASK: next_rdata[2:0] = mask;
        default: next_rdata = 32'h0;
      endcase
      if (s_axi_araddr == ADDR_BUF) next_full = 1'b0;
    end
    if (do_w) begin
      next_aw_hold = 1'b0; next_w_hold = 1'b0; next_bvalid = 1'b1;
      next_bresp = known(wa) ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr) begin
      unique case (wa)
        ADDR_CTRL: next_ctrl = w_d[7:0];
        ADDR_BUF: begin
          next_buf = w_d[7:0];
          next_sr = w_d[7:0];
        end
        ADDR_OWN: next_own = w_d[7:0];
        ADDR_PORT: next_dir = w_d[7:0];
        ADDR_IRQ: next_ist = ist & ~w_d[2:0];
        ADDR_MASK: next_mask = w_d[2:0];
        default: next_ctrl = next_ctrl;
      endcase
    end
    if (!ctrl[CTL_REL]) next_scl_lo = scl_lo;
    else next_scl_lo = 1'b0;
    // Link side
    if (en) begin
      if (start_det) begin
        next_s_f = 1'b1; next_p_f = 1'b0; ev[IRQ_START] = 1'b1;
        next_st = ST_ADDR; next_cnt = 4'h0; next_sda_lo = 1'b0;
        next_rw = 1'b0;
      end else if (stop_det) begin
        next_p_f = 1'b1; next_s_f = 1'b0; ev[IRQ_STOP] = 1'b1;
        next_st = ST_IDLE; next_sda_lo = 1'b0;
      end else if (slave_on) begin
        unique case (st)
          ST_IDLE: begin
            // Ninth fall after a not-acknowledged byte still counts as a transfer
            if (scl_fall && cnt == 4'h9) begin
              ev[IRQ_BYTE] = 1'b1;
              next_cnt = 4'h0;
            end
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise && cnt < 4'h8) next_sr = {sr[6:0], sync2.sda};
            if (scl_rise) next_cnt = cnt + 4'h1;
            if (scl_fall && cnt == 4'h8) begin
              if (st == ST_ADDR && sr[7:1] != own[7:1]) begin
                next_st = ST_IDLE;
              end else if (full || ctrl[CTL_OVF]) begin
                next_ctrl[CTL_OVF] = 1'b1;
                ev[IRQ_BYTE] = 1'b1;
              end else begin
                next_sda_lo = 1'b1;
                next_buf = sr; next_full = st == ST_RX;
                next_da = st == ST_RX;
                if (st == ST_ADDR && sr[0]) begin
                  next_rw = 1'b1; next_full = 1'b0;
                end
              end
            end
            if (scl_fall && cnt == 4'h9) begin
              next_sda_lo = 1'b0; next_cnt = 4'h0;
              ev[IRQ_BYTE] = 1'b1;
              if (rw) begin
                next_ctrl[CTL_REL] = 1'b0;
                next_scl_lo = 1'b1;
                next_st = ST_TX;
                next_da = 1'b1;
              end else begin
                next_st = ST_RX;
              end
            end
          end
          ST_TX: begin
            // First bit sits on SDA before SCL is let go: no false start
            if (cnt == 4'h0 && scl_lo) begin
              next_sda_lo = ~sr[7];
            end
            if (scl_fall) begin
              if (cnt < 4'h7) begin
                next_sda_lo = ~sr[6];
                next_sr = {sr[6:0], 1'b0};
                next_cnt = cnt + 4'h1;
              end else begin
                next_sda_lo = 1'b0; next_st = ST_ACKIN;
              end
            end
          end
          ST_ACKIN: begin
            if (scl_rise) begin
              if (sync2.sda) begin
                next_st = ST_IDLE; next_rw = 1'b0; next_da = 1'b0;
                next_full = 1'b0; next_cnt = 4'h9;
              end else begin
                next_cnt = 4'h9;
              end
            end
            if (scl_fall && cnt == 4'h9) begin
              ev[IRQ_BYTE] = 1'b1;
              next_ctrl[CTL_REL] = 1'b0; next_scl_lo = 1'b1;
              next_cnt = 4'h0; next_st = ST_TX;
            end
          end
          default: next_st = ST_IDLE;
        endcase
      end
    end else begin
      next_s_f = 1'b0; next_p_f = 1'b0;
      next_st = ST_IDLE; next_sda_lo = 1'b0; next_scl_lo = 1'b0;
      next_rw = 1'b0; next_da = 1'b0; next_cnt = 4'h0;
    end
    next_ist = next_ist | ev; // Set beats a same-cycle clear
    next_irq = |(next_ist & next_mask);
  end

  // ***********************************************************
  // Registers
  // ***********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= RST_CTRL; own <= 8'h00; buf_q <= 8'h00; sr <= 8'h00;
      dir <= RST_DIR; full <= 1'b0; rw <= 1'b0; s_f <= 1'b0; p_f <= 1'b0;
      da <= 1'b0; sda_lo <= 1'b0; scl_lo <= 1'b0; cnt <= 4'h0;
      ist <= 3'h0; mask <= RST_MASK; st <= ST_IDLE; aw_hold <= 1'b0;
      w_hold <= 1'b0; aw_a <= 8'h00; w_d <= 32'h0; w_s <= 4'h0;
      bvalid <= 1'b0; rvalid <= 1'b0; bresp <= 2'h0; rresp <= 2'h0;
      rdata <= 32'h0; irq_q <= 1'b0;
      pin_out <= '{scl: 1'b0, sda: 1'b0};
      pin_oe <= '{scl: 1'b0, sda: 1'b0};
    end else begin
      ctrl <= next_ctrl; own <= next_own; buf_q <= next_buf; sr <= next_sr;
      dir <= next_dir; full <= next_full; rw <= next_rw; s_f <= next_s_f;
      p_f <= next_p_f; da <= next_da; sda_lo <= next_sda_lo;
      scl_lo <= next_scl_lo; cnt <= next_cnt; ist <= next_ist;
      mask <= next_mask; st <= next_st; aw_hold <= next_aw_hold;
      w_hold <= next_w_hold; aw_a <= next_aw_a; w_d <= next_w_d;
      w_s <= next_w_s; bvalid <= next_bvalid; rvalid <= next_rvalid;
      bresp <= next_bresp; rresp <= next_rresp; rdata <= next_rdata;
      irq_q <= next_irq;
      // Open drain: only ever drives zero, whatever else is asked
      pin_out <= '{scl: 1'b0, sda: 1'b0};
      pin_oe.scl <= next_scl_lo | ~next_dir[DIR_SCL];
      pin_oe.sda <= next_sda_lo | ~next_dir[DIR_SDA];
    end
  end

  assign s_axi_awready = ~aw_hold;
  assign s_axi_wready = ~w_hold;
  assign s_axi_arready = ~rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign irq = irq_q;

  // ***********************************************************
  // Assertions
  // ***********************************************************
  default clocking a_clk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Link events that the slave decoder acts on
  logic quiet;
  assign quiet = slave_on && !start_det && !stop_det;

  sequence s_addr_read_done;
    quiet && st == ST_ADDR && scl_fall && cnt == 4'h9 && rw;
  endsequence
  sequence s_byte_refused;
    quiet && (st == ST_ADDR || st == ST_RX) && scl_fall && cnt == 4'h8 &&
      (full || ctrl[CTL_OVF]) && !(st == ST_ADDR && sr[7:1] != own[7:1]);
  endsequence
  sequence s_ack_low;
    quiet && st == ST_ACKIN && scl_rise && !sync2.sda;
  endsequence
  sequence s_ack_high;
    quiet && st == ST_ACKIN && scl_rise && sync2.sda;
  endsequence
  sequence s_ninth_fall;
    quiet && st == ST_ACKIN && scl_fall && cnt == 4'h9;
  endsequence
  sequence s_tx_fall;
    quiet && st == ST_TX && scl_fall && cnt < 4'h7;
  endsequence
  // Link edges left out: they may shift the register the same cycle
  sequence s_buf_written;
    aw_hold && w_hold && !bvalid && w_s[0] && aw_a == ADDR_BUF &&
      !scl_rise && !scl_fall;
  endsequence

  a_hold_scl_low: assert property (
    (scl_lo && !ctrl[CTL_REL]) |=> pin_oe.scl)
    else $error("SCL not held while release bit clear");
  a_never_drive_high: assert property (
    pin_out.sda == 1'b0 && pin_out.scl == 1'b0)
    else $error("Pin driven high");
  a_flags_disabled: assert property (
    !en |=> !s_f && !p_f)
    else $error("Start/stop flag set while disabled");
  a_start_sets: assert property (
    (en && start_det) |=> s_f && !p_f && ist[IRQ_START])
    else $error("Start not recorded");
  a_stop_sets: assert property (
    (en && !start_det && stop_det) |=> p_f && ist[IRQ_STOP])
    else $error("Stop not recorded");
  a_bus_free: assert property (
    bus_free == (p_f || (!s_f && !p_f)))
    else $error("Bus free mismatch");
  a_free_after_stop: assert property (
    (en && !start_det && stop_det) |=> bus_free)
    else $error("Bus not free after stop");
  a_nack_reset: assert property (
    s_ack_high |=> st == ST_IDLE && !rw)
    else $error("No acknowledge did not reset slave");
  a_irq_level: assert property (
    ##1 irq == $past(|(next_ist & next_mask)))
    else $error("Interrupt output wrong");
  a_addr_stretch: assert property (
    s_addr_read_done |=> !ctrl[CTL_REL] && scl_lo && st == ST_TX)
    else $error("Read address not followed by stretch");
  a_byte_refused: assert property (
    s_byte_refused |=> ctrl[CTL_OVF] && !sda_lo)
    else $error("Refused byte not flagged");
  a_ack_latched: assert property (
    s_ack_low |=> st == ST_ACKIN && cnt == 4'h9)
    else $error("Acknowledge not latched");
  a_byte_flag: assert property (
    s_ninth_fall |=> ist[IRQ_BYTE])
    else $error("Byte flag not set on ninth fall");
  a_next_byte_hold: assert property (
    s_ninth_fall |=> st == ST_TX && scl_lo && !ctrl[CTL_REL])
    else $error("SCL not held for next byte");
  a_tx_shift: assert property (
    s_tx_fall |=> sda_lo == !$past(sr[6]))
    else $error("Wrong bit shifted out");
  a_buf_to_shift: assert property (
    s_buf_written |=> sr == $past(w_d[7:0]))
    else $error("Buffer write missed shift register");
  a_monitor_start: assert property (
    (en && ctrl[CTL_MODE_LO +: 4] == MODE_IDLE_MON && start_det) |=>
      ist[IRQ_START] && s_f)
    else $error("Monitor mode missed start");
endmodule

// ---- i2cs_master_model.sv ----
// Behavioural bus master for the serial port bench.
// Assumes pull-up wires resolved by the bench, paced by aclk.
`timescale 1ns/1ps
module i2cs_master_model (
  input wire logic aclk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  int stuck = 0;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Half of the 400 ns link period
  task automatic half();
    repeat (4) @(posedge aclk);
  endtask
  // Slave may stretch: wait until SCL is really high
  task automatic rise();
    int n;
    n = 0;
    scl_low <= 1'b0;
    @(posedge aclk);
    while (scl !== 1'b1 && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 5000) stuck++;
  endtask
  // Falls one cycle before SDA moves, so no false start or stop
  task automatic put(input logic b);
    sda_low <= !b;
    half();
    rise();
    half();
    scl_low <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic get(output logic b);
    sda_low <= 1'b0;
    half();
    rise();
    half();
    b = sda;
    scl_low <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    half();
    rise();
    half();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b1;
    half();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    half();
    rise();
    half();
    sda_low <= 1'b0;
    half();
  endtask
  task automatic byte_out(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) put(v[i]);
    get(ack);
  endtask
  task automatic byte_in(input logic nak, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) get(v[i]);
    put(nak);
  endtask
endmodule

// ---- i2c_slave_transmit_bus_monitor_bench.sv ----
// Self-checking bench for the slave-transmit port with bus monitor.
// Assumes the design package and the master model are compiled first.
`timescale 1ns/1ps
module i2c_slave_transmit_bus_monitor_bench;
  import i2cs_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  i2cs_pins_t pin_in, pin_out, pin_oe;
  logic scl_w, sda_w, m_scl, m_sda, tx_on, prev_scl, prev_oe;
  int errors = 0;
  int total_checks = 0;
  // Pull-ups on both wires
  assign scl_w = !(pin_oe.scl | m_scl);
  assign sda_w = !(pin_oe.sda | m_sda);
  assign pin_in = {scl_w, sda_w};
  i2cs_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
    .pin_oe, .irq);
  i2cs_master_model m (.aclk, .scl(scl_w), .sda(sda_w),
    .scl_low(m_scl), .sda_low(m_sda));
  // ***********************************************************
  // Tasks
  // ***********************************************************
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_t, w_t, b_t;
    n = 0;
    b_t = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Sample at the falling edge: values that stand at the next rise
    while (!b_t && n < 50) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid === 1'b1;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      n++;
    end
    if (!b_t) begin
      errors++;
      close_out();
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    logic ar_t, r_t;
    n = 0;
    r_t = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_t && n < 50) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid === 1'b1;
      if (r_t) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      n++;
    end
    if (!r_t) begin
      errors++;
      close_out();
    end
  endtask
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] mk, e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d & mk);
  endtask
  // Slave data must hold while SCL is high
  always @(negedge aclk) begin
    if (tx_on && scl_w && prev_scl) chk("sda hold", prev_oe, pin_oe.sda);
    prev_scl <= scl_w;
    prev_oe <= pin_oe.sda;
  end
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    repeat (100000) @(posedge aclk);
    errors++;
    close_out();
  end
  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic ak;
    logic [7:0] b, got;
    logic [7:0] q[$];
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, tx_on} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'h62d426b3));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc("ctrl", ADDR_CTRL, 32'hff, 32'h0);
    rc("dir", ADDR_PORT, 32'hff, 32'hff);
    rc("mask", ADDR_MASK, 32'h7, 32'h0);
    rc("status", ADDR_STATUS, 32'h58, 32'h40);
    rd(8'h1c, d, r);
    chk("bad resp", RESP_SLVERR, r);
    wr(ADDR_OWN, 32'ha0);
    wr(ADDR_MASK, 32'h7);
    wr(ADDR_CTRL, 32'h26);
    m.start();
    rc("irq", ADDR_IRQ, 32'h7, 32'h2);
    chk("irq pin", 1, irq);
    rc("status", ADDR_STATUS, 32'h58, 32'h08);
    wr(ADDR_IRQ, 32'h7);
    m.byte_out(8'ha1, ak);
    chk("addr ack", 0, ak);
    rc("status", ADDR_STATUS, 32'h5, 32'h4);
    rc("irq", ADDR_IRQ, 32'h7, 32'h1);
    wr(ADDR_IRQ, 32'h7);
    for (int k = 0; k < 2; k++) begin
      b = $urandom;
      q.push_back(b);
      fork
        m.byte_in(k == 1, got);
        begin
          repeat (40) @(posedge aclk);
          chk("scl held", 0, scl_w);
          rc("release", ADDR_CTRL, 32'h10, 32'h0);
          if (k == 0) rc("buf", ADDR_BUF, 32'hff, 32'ha1);
          wr(ADDR_BUF, b);
          tx_on = 1'b1;
          wr(ADDR_CTRL, 32'h36);
        end
      join
      tx_on = 1'b0;
      // Ninth fall reaches the logic a few cycles after the wire
      repeat (4) @(posedge aclk);
      chk("tx byte", q.pop_front(), got);
      rc("irq", ADDR_IRQ, 32'h7, 32'h1);
      wr(ADDR_IRQ, 32'h7);
    end
    rc("status", ADDR_STATUS, 32'h4, 32'h0);
    m.stop();
    rc("status", ADDR_STATUS, 32'h58, 32'h50);
    rc("irq", ADDR_IRQ, 32'h7, 32'h4);
    rd(ADDR_BUF, d, r);
    m.start();
    m.byte_out(8'ha0, ak);
    chk("waddr ack", 0, ak);
    m.byte_out(8'h5a, ak);
    chk("data ack", 0, ak);
    m.byte_out(8'hc3, ak);
    chk("ovf ack", 1, ak);
    rc("ovf", ADDR_CTRL, 32'h40, 32'h40);
    m.stop();
    wr(ADDR_CTRL, 32'h0);
    rc("status", ADDR_STATUS, 32'h58, 32'h40);
    wr(ADDR_PORT, 32'he7);
    @(posedge aclk);
    chk("pin oe", 3, pin_oe);
    chk("pin out", 0, pin_out);
    chk("wires", 0, {scl_w, sda_w});
    wr(ADDR_PORT, 32'hf7);
    @(posedge aclk);
    chk("pin oe", 2, pin_oe);
    wr(ADDR_PORT, 32'hff);
    wr(ADDR_IRQ, 32'h7);
    wr(ADDR_CTRL, 32'h2b);
    m.start();
    rc("irq", ADDR_IRQ, 32'h7, 32'h2);
    chk("irq pin", 1, irq);
    wr(ADDR_MASK, 32'h5);
    @(posedge aclk);
    chk("irq masked", 0, irq);
    m.stop();
    rc("irq", ADDR_IRQ, 32'h7, 32'h6);
    chk("irq pin", 1, irq);
    chk("stretch", 0, m.stuck);
    close_out();
  end
endmodule
